// ---- rtl/pamx_pkg.sv ----
// Constants and carrier types for the port alternate-function mux
package pamx_pkg;
  // Package variants by pin count
  localparam int PINS_8  = 8;
  localparam int PINS_20 = 20;
  localparam int PINS_28 = 28;

  // Register byte offsets on the bus, one aligned word each
  localparam logic [7:0] OFF_PA_AF     = 8'h00;
  localparam logic [7:0] OFF_PB_AF     = 8'h04;
  localparam logic [7:0] OFF_PB_SEL1   = 8'h08;
  localparam logic [7:0] OFF_PB_SEL2   = 8'h0c;
  localparam logic [7:0] OFF_PC_AF     = 8'h10;
  localparam logic [7:0] OFF_PC_SEL1   = 8'h14;
  localparam logic [7:0] OFF_PC_SEL2   = 8'h18;
  localparam logic [7:0] OFF_LED_EN    = 8'h1c;
  localparam logic [7:0] OFF_LED_LVL_H = 8'h20;
  localparam logic [7:0] OFF_LED_LVL_L = 8'h24;
  localparam logic [7:0] OFF_STATUS    = 8'h28;

  // Number of writable registers, all below the status word
  localparam logic [3:0] NREG = 4'ha;
  // Reset value of every writable register
  localparam logic [7:0] CFG_RST = 8'h00;

  // Status word bit positions
  localparam int ST_DBG    = 0;
  localparam int ST_RSTSEQ = 1;
  localparam int ST_XTAL   = 2;
  localparam int ST_PA2    = 3;

  // LED sink level codes, {high half bit, low half bit}
  localparam logic [1:0] LVL_3MA  = 2'h0;
  localparam logic [1:0] LVL_7MA  = 2'h1;
  localparam logic [1:0] LVL_13MA = 2'h2;
  localparam logic [1:0] LVL_20MA = 2'h3;

  // Port pins that carry fixed roles
  localparam int PB_CLK_PIN = 3;
  localparam int PC_CMP_PIN = 3;

  // Bus response
  localparam logic HRESP_OKAY = 1'b0;

  // Drive request or drive result for one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pamx_pins_t;
endpackage

// ---- rtl/pamx_mux.sv ----
// Port A/B/C alternate-function mux, LED sink control and shared pins
//
// The AHB-Lite interface to the registers and the address map were decided locally.
module pamx_mux
  import pamx_pkg::*;
#(
  parameter int PIN_COUNT = pamx_pkg::PINS_28  // Package variant
)(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic [7:0]           pa_pin_in,
  input  wire logic [7:0]           pb_pin_in,
  input  wire logic [7:0]           pc_pin_in,
  input  wire pamx_pkg::pamx_pins_t gpio_a,
  input  wire pamx_pkg::pamx_pins_t gpio_b,
  input  wire pamx_pkg::pamx_pins_t gpio_c,
  input  wire pamx_pkg::pamx_pins_t pa_func,
  input  wire logic                 comparator_result_out,
  input  wire logic                 xtal_en,
  input  wire logic                 sys_reset_seq,
  input  wire logic                 dbg_unlock_seen,
  input  wire logic                 dbg_out,
  input  wire logic                 dbg_oe,
  output pamx_pkg::pamx_pins_t      pa_drive,
  output pamx_pkg::pamx_pins_t      pb_drive,
  output pamx_pkg::pamx_pins_t      pc_drive,
  output logic [7:0]                pa_func_in,
  output logic [7:0]                adc_connect,
  output logic                      vref_pb_connect,
  output logic                      vref_pc_connect,
  output logic                      ext_clock_in,
  output logic                      comparator_pos_in,
  output logic                      comparator_neg_in,
  output logic [7:0]                led_sink_enable,
  output logic [15:0]               led_sink_level,
  output logic                      chip_reset_hold,
  output logic                      dbg_pin_in,
  output logic                      debug_unlocked
);
  import pamx_pkg::*;

  // Variant flags
  localparam logic IS8  = (PIN_COUNT == PINS_8);
  localparam logic IS20 = (PIN_COUNT == PINS_20);
  localparam logic IS28 = (PIN_COUNT == PINS_28);

  logic [7:0] cfg_r [NREG];      // Writable configuration bytes
  logic       wr_pend_r;         // Write data phase pending
  logic [3:0] wa_r;              // Word index of pending write
  logic       dbg_unl_r;         // Debug owns port A bit zero
  logic       rseq_q_r;          // Reset sequence, last cycle

  // Register index decode from a byte offset
  function automatic logic [3:0] ridx(input logic [7:0] off);
    ridx = off[5:2];
  endfunction

  // Named views of the configuration bytes
  wire [7:0] pa_af   = cfg_r[ridx(OFF_PA_AF)];
  wire [7:0] pb_af   = cfg_r[ridx(OFF_PB_AF)];
  wire [7:0] pb_sel1 = cfg_r[ridx(OFF_PB_SEL1)];
  wire [7:0] pc_af   = cfg_r[ridx(OFF_PC_AF)];
  wire [7:0] pc_sel1 = cfg_r[ridx(OFF_PC_SEL1)];
  wire [7:0] led_en  = cfg_r[ridx(OFF_LED_EN)];
  wire [7:0] led_hi  = cfg_r[ridx(OFF_LED_LVL_H)];
  wire [7:0] led_lo  = cfg_r[ridx(OFF_LED_LVL_L)];

  // Bus decode; upper address bits are not checked, so the map aliases
  wire       addr_ok = hsel & htrans[1] & hready;
  wire [3:0] ra      = haddr[5:2];
  wire [7:0] status  = 8'h00 | ({7'h00, dbg_unl_r} << ST_DBG)
                     | ({7'h00, sys_reset_seq} << ST_RSTSEQ)
                     | ({7'h00, xtal_en} << ST_XTAL)
                     | ({7'h00, pa_pin_in[2]} << ST_PA2);
  wire [7:0] rd_byte = (ra < NREG) ? cfg_r[ra]
                     : (ra == ridx(OFF_STATUS)) ? status : 8'h00;

  // Select decode: bit one picks the second function once enabled
  wire [7:0] pb_fn1 = pb_af & pb_sel1;
  wire [7:0] pc_fn1 = pc_af & pc_sel1;
  wire       pb_clk = pb_af[PB_CLK_PIN] & ~pb_sel1[PB_CLK_PIN];
  wire       pc_cmp = pc_af[PC_CMP_PIN] & ~pc_sel1[PC_CMP_PIN];

  // Analog channel map: B0-B3 to 0-3, C0-C2 to 4-6, B4 to 7
  wire [7:0] adc_nxt = {pb_fn1[4], pc_fn1[2:0], pb_fn1[3:0]};

  // Port B: every function is analog or input, so enable kills drive
  wire [7:0] pb_oe_nxt = gpio_b.oe & ~pb_af;

  // Port C: only the comparator output drives; reserved stays off
  wire [7:0] pc_cmp_v  = {4'h0, pc_cmp, 3'h0};
  wire [7:0] pc_oe_nxt = (gpio_c.oe & ~pc_af) | pc_cmp_v;
  wire [7:0] pc_o_nxt  = (gpio_c.out & ~pc_af)
                       | (pc_cmp_v & {8{comparator_result_out}});

  // Port A per-pin overrides
  wire       rst8   = IS8 & sys_reset_seq;
  wire [7:0] pa_kill = {5'h00, rst8, xtal_en, xtal_en | (rst8 & ~dbg_unl_r)};
  logic [7:0] pa_o_nxt;          // Port A output, before registering
  logic [7:0] pa_oe_nxt;         // Port A enable, before registering
  logic [7:0] pa_in_nxt;         // Port A inputs routed to peripherals

  // Port A: the timer decides in/out, so its own enable is passed on
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pa
      wire dbg_own = (i == 0) & dbg_unl_r & IS8 & ~xtal_en;
      assign pa_o_nxt[i]  = dbg_own ? dbg_out
                          : pa_af[i] ? pa_func.out[i]
                          : gpio_a.out[i];
      assign pa_oe_nxt[i] = dbg_own ? dbg_oe
                          : pa_kill[i] ? 1'b0
                          : pa_af[i] ? pa_func.oe[i]
                          : gpio_a.oe[i];
      assign pa_in_nxt[i] = pa_af[i] & ~pa_kill[i] & ~dbg_own
                          & pa_pin_in[i];
    end
  endgenerate

  // Per-pin LED sink level, high half above low half
  logic [15:0] lvl_nxt;          // Packed two-bit levels
  generate
    for (genvar i = 0; i < 8; i++) begin : g_lvl
      assign lvl_nxt[2*i+1:2*i] = {led_hi[i], led_lo[i]};
    end
  endgenerate

  // Bus answers at once; a read in the cycle after a write to the
  // same word returns the old value
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Bus address phase capture and read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 4'h0;
      hrdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_r <= addr_ok & hwrite;
      wa_r      <= ra;
      if (addr_ok & ~hwrite) begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Register writes in the data phase; unmapped words are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NREG; k++) begin
        cfg_r[k] <= CFG_RST;
      end
    end else if (clk_en && wr_pend_r && wa_r < NREG) begin
      cfg_r[wa_r] <= hwdata[7:0];
    end
  end

  // Debug unlock: a new reset sequence clears it, a pattern seen during an
  // 8-pin reset sequence sets it, and set wins when both land in one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dbg_unl_r <= 1'b0;
      rseq_q_r  <= 1'b0;
    end else if (clk_en) begin
      rseq_q_r <= sys_reset_seq;
      if (rst8 & dbg_unlock_seen) begin
        dbg_unl_r <= 1'b1;
      end else if (sys_reset_seq & ~rseq_q_r) begin
        dbg_unl_r <= 1'b0;
      end
    end
  end

  // Registered pin drives and peripheral connections
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa_drive          <= '0;
      pb_drive          <= '0;
      pc_drive          <= '0;
      pa_func_in        <= 8'h00;
      adc_connect       <= 8'h00;
      vref_pb_connect   <= 1'b0;
      vref_pc_connect   <= 1'b0;
      ext_clock_in      <= 1'b0;
      comparator_pos_in <= 1'b0;
      comparator_neg_in <= 1'b0;
      led_sink_enable   <= 8'h00;
      led_sink_level    <= 16'h0000;
      chip_reset_hold   <= 1'b0;
      dbg_pin_in        <= 1'b0;
    end else if (clk_en) begin
      pa_drive          <= '{out: pa_o_nxt, oe: pa_oe_nxt};
      pb_drive          <= '{out: gpio_b.out, oe: pb_oe_nxt};
      pc_drive          <= '{out: pc_o_nxt, oe: pc_oe_nxt};
      pa_func_in        <= pa_in_nxt;
      adc_connect       <= adc_nxt;
      vref_pb_connect   <= IS28 & pb_fn1[5];
      vref_pc_connect   <= IS20 & pc_fn1[2];
      ext_clock_in      <= pb_clk & pb_pin_in[PB_CLK_PIN];
      comparator_pos_in <= pc_fn1[0] & pc_pin_in[0];
      comparator_neg_in <= pc_fn1[1] & pc_pin_in[1];
      led_sink_enable   <= led_en;
      led_sink_level    <= lvl_nxt;
      chip_reset_hold   <= rst8 & ~pa_pin_in[2];
      dbg_pin_in        <= IS8 & pa_pin_in[0];
    end
  end

  assign debug_unlocked = dbg_unl_r;

  // Checks on the mux, all in the one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_led_addr;
    clk_en && addr_ok && hwrite && ra == ridx(OFF_LED_EN);
  endsequence
  sequence s_wr_led_data;
    clk_en [*1];
  endsequence

  property p_pa_direct;
    clk_en && pa_af[7] |=> pa_drive.oe[7] == $past(pa_func.oe[7])
                           && pa_drive.out[7] == $past(pa_func.out[7]);
  endproperty
  a_pa_direct: assert property (p_pa_direct)
    else $error("port A enable did not pass the function through");

  property p_pb_adc;
    clk_en && pb_af[0] && pb_sel1[0] |=> adc_connect[0] && !pb_drive.oe[0];
  endproperty
  a_pb_adc: assert property (p_pb_adc)
    else $error("port B pin zero not routed to analog channel");

  property p_pb_clk;
    clk_en && pb_clk |=> ext_clock_in == $past(pb_pin_in[PB_CLK_PIN]);
  endproperty
  a_pb_clk: assert property (p_pb_clk)
    else $error("external clock input not taken from port B pin");

  property p_pc_cmp;
    clk_en && pc_af[3] && !pc_sel1[3] |=> pc_drive.oe[3]
      && pc_drive.out[3] == $past(comparator_result_out);
  endproperty
  a_pc_cmp: assert property (p_pc_cmp)
    else $error("comparator output not driven on port C");

  // Pin two selected: analog always, reference only on the 20-pin part
  property p_pc_vref;
    clk_en && pc_af[2] && pc_sel1[2] |=> vref_pc_connect == IS20
                                        && adc_connect[6];
  endproperty
  a_pc_vref: assert property (p_pc_vref)
    else $error("port C reference connected on wrong variant");

  // Byte lands in the data phase, the driver flop one edge after that
  property p_led_wr;
    s_wr_led_addr ##1 s_wr_led_data ##1 clk_en |=>
      led_sink_enable == $past(hwdata[7:0], 2);
  endproperty
  a_led_wr: assert property (p_led_wr)
    else $error("LED enable write did not reach the drivers");

  property p_rst_hold;
    clk_en && rst8 && !pa_pin_in[2] |=> chip_reset_hold && !pa_drive.oe[2];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("low reset pin did not hold the chip in reset");

  property p_dbg_unlock;
    clk_en && rst8 && dbg_unlock_seen |=> debug_unlocked [*2];
  endproperty
  a_dbg_unlock: assert property (p_dbg_unlock)
    else $error("unlock pattern did not hand the pin to debug");

  property p_xtal;
    clk_en && xtal_en |=> pa_drive.oe[1:0] == 2'h0
                          && pa_func_in[1:0] == 2'h0;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal enable did not disable port A pins");

  property p_reserved;
    clk_en && pb_af[6] |=> !pb_drive.oe[6]
      && adc_connect[7] == ($past(pb_af[4]) && $past(pb_sel1[4]));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved port B selection drove the pin");
endmodule

// ---- sim/pamx_far.sv ----
// Far-side pad model: level seen on each port pin
module pamx_far
  import pamx_pkg::*;
(
  input  wire pamx_pkg::pamx_pins_t drv_a,
  input  wire pamx_pkg::pamx_pins_t drv_b,
  input  wire pamx_pkg::pamx_pins_t drv_c,
  input  wire logic [23:0]          ext,
  output logic [23:0]               pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stacked enables and drive values, port C on top
  wire [23:0] oe_all = {drv_c.oe, drv_b.oe, drv_a.oe};
  wire [23:0] out_all = {drv_c.out, drv_b.out, drv_a.out};
  // Driven pad shows its driver, else the outside world wins
  assign pins = (oe_all & out_all) | (~oe_all & ext);
endmodule

// ---- sim/port_alt_function_mux_bench.sv ----
// Self-checking bench for the port alternate-function mux
module port_alt_function_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pamx_pkg::*;
  // Bus, strap and peripheral drive, all set at time zero
  logic        clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  pamx_pins_t  gpio_a = '0, gpio_b = '0, gpio_c = '0, pa_func = '0;
  pamx_pins_t  pa_drv, pb_drv, pc_drv;
  // Side inputs for the comparator, crystal, reset sequence and debug
  logic        cmp_out = 1'b0, xtal = 1'b0, rseq = 1'b0;
  logic        unl = 1'b0, dbg_o = 1'b0, dbg_e = 1'b0;
  logic [7:0]  pa_fin, adc, led_en;
  logic [15:0] led_lvl;
  logic        vref_b, vref_c, ck_in, cmp_p, cmp_n, rhold, dbg_in, dbg_u;
  logic [23:0] ext = 24'h0, pins;
  // Outputs of the 8-pin part and the pads that it sees
  pamx_pins_t  pa_drv8;
  logic        rhold8, dbg_in8, dbg_u8;
  logic [23:0] pins8;
  int          n_mismatch = 0, compares = 0, cycles = 0;
  // Table row: write, or read with the expected word in d
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} pamx_row_t;
  pamx_row_t rows [12] = '{
    '{1'b0, OFF_PA_AF, 32'h0}, '{1'b0, OFF_LED_LVL_L, 32'h0},
    '{1'b1, OFF_PB_SEL1, 32'hffffff3c}, '{1'b0, OFF_PB_SEL1, 32'h3c},
    '{1'b1, OFF_PB_SEL2, 32'ha5}, '{1'b0, OFF_PB_SEL2, 32'ha5},
    '{1'b1, OFF_PC_SEL2, 32'h5a}, '{1'b0, OFF_PC_SEL2, 32'h5a},
    '{1'b1, OFF_STATUS, 32'hff}, '{1'b0, OFF_STATUS, 32'h0},
    '{1'b1, 8'h2c, 32'hff}, '{1'b0, 8'h2c, 32'h0}};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  pamx_mux #(.PIN_COUNT(PINS_28)) dut_u (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
    .hresp(hresp), .pa_pin_in(pins[7:0]), .pb_pin_in(pins[15:8]),
    .pc_pin_in(pins[23:16]), .gpio_a(gpio_a), .gpio_b(gpio_b),
    .gpio_c(gpio_c), .pa_func(pa_func), .comparator_result_out(cmp_out),
    .xtal_en(xtal), .sys_reset_seq(rseq), .dbg_unlock_seen(unl),
    .dbg_out(dbg_o), .dbg_oe(dbg_e), .pa_drive(pa_drv), .pb_drive(pb_drv),
    .pc_drive(pc_drv), .pa_func_in(pa_fin), .adc_connect(adc),
    .vref_pb_connect(vref_b), .vref_pc_connect(vref_c),
    .ext_clock_in(ck_in), .comparator_pos_in(cmp_p),
    .comparator_neg_in(cmp_n), .led_sink_enable(led_en),
    .led_sink_level(led_lvl), .chip_reset_hold(rhold),
    .dbg_pin_in(dbg_in), .debug_unlocked(dbg_u));

  pamx_far far_u (.drv_a(pa_drv), .drv_b(pb_drv), .drv_c(pc_drv),
    .ext(ext), .pins(pins));

  // 8-pin part on the same inputs, for the shared reset and debug pins
  pamx_mux #(.PIN_COUNT(PINS_8)) dut8_u (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(), .hrdata(),
    .hresp(), .pa_pin_in(pins8[7:0]), .pb_pin_in(pins8[15:8]),
    .pc_pin_in(pins8[23:16]), .gpio_a(gpio_a), .gpio_b(gpio_b),
    .gpio_c(gpio_c), .pa_func(pa_func), .comparator_result_out(cmp_out),
    .xtal_en(xtal), .sys_reset_seq(rseq), .dbg_unlock_seen(unl),
    .dbg_out(dbg_o), .dbg_oe(dbg_e), .pa_drive(pa_drv8), .pb_drive(),
    .pc_drive(), .pa_func_in(), .adc_connect(), .vref_pb_connect(),
    .vref_pc_connect(), .ext_clock_in(), .comparator_pos_in(),
    .comparator_neg_in(), .led_sink_enable(), .led_sink_level(),
    .chip_reset_hold(rhold8), .dbg_pin_in(dbg_in8),
    .debug_unlocked(dbg_u8));

  pamx_far far8_u (.drv_a(pa_drv8), .drv_b(pb_drv), .drv_c(pc_drv),
    .ext(ext), .pins(pins8));

  // One compare for every kind of result, widened to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Single AHB-Lite word transfer; waits on hready, never on a count
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Config lands one edge, pad feedback one more
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] q;
    settle();
    chk({led_lvl, led_en, adc}, 32'h0);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Table: reset values, stored-but-ignored sets, read-only, unmapped
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) chk(q, rows[i].d);
    end
    chk(hresp, HRESP_OKAY);
    // Port B: selects first, then enable, so no stray function appears
    @(posedge clk);
    gpio_b <= '{8'hff, 8'hff};
    ext <= 24'h000800;
    wr(OFF_PB_SEL1, 32'h3f);
    wr(OFF_PB_SEL2, 32'hc0);
    wr(OFF_PB_AF, 32'hff);
    settle();
    chk(adc, 8'h8f);
    chk({vref_b, ck_in}, 2'b10);
    chk(pb_drv.oe, 8'h00);
    wr(OFF_PB_SEL1, 32'h00);
    settle();
    chk({vref_b, adc}, 9'h0);
    chk(ck_in, 1'b1);
    wr(OFF_PB_AF, 32'h00);
    settle();
    chk({pb_drv, ck_in}, 17'h1fffe);
    // Port C: analog pair, comparator out, then pin three reserved
    @(posedge clk);
    gpio_c <= '{8'h00, 8'hff};
    cmp_out <= 1'b1;
    ext <= 24'h010000;
    wr(OFF_PC_SEL1, 32'h07);
    wr(OFF_PC_AF, 32'h0f);
    settle();
    chk({vref_c, adc}, 9'h070);
    chk({cmp_p, cmp_n}, 2'b10);
    chk({pc_drv.oe, pc_drv.out[3]}, 9'h1f1);
    wr(OFF_PC_SEL1, 32'hff);
    settle();
    chk(pc_drv.oe, 8'hf0);
    // LED sink: every level code appears on two of the pins
    wr(OFF_LED_EN, 32'ha5);
    wr(OFF_LED_LVL_H, 32'hf0);
    wr(OFF_LED_LVL_L, 32'hcc);
    settle();
    chk(led_en, 8'ha5);
    chk(led_lvl, 16'hfa50);
    // Port A: enable alone connects; oe comes from the timer side
    @(posedge clk);
    gpio_a <= '{8'h55, 8'h0f};
    pa_func <= '{8'haa, 8'hf0};
    wr(OFF_PA_AF, 32'hf0);
    settle();
    chk(pa_drv, 16'ha5ff);
    chk(pa_fin, 8'ha0);
    // Clock enable low: new GPIO requests must not reach the pads
    @(posedge clk);
    clk_en <= 1'b0;
    gpio_a <= '0;
    settle();
    chk(pa_drv, 16'ha5ff);
    @(posedge clk);
    clk_en <= 1'b1;
    gpio_a <= '{8'h55, 8'h0f};
    xtal <= 1'b1;
    settle();
    chk(pa_drv.oe, 8'hfc);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk(q, 32'h0c);
    // 8-pin part: reset pin holds, then unlock hands bit zero to debug
    @(posedge clk);
    xtal <= 1'b0;
    rseq <= 1'b1;
    ext <= 24'h000001;
    {dbg_o, dbg_e} <= 2'b11;
    settle();
    chk({rhold8, pa_drv8.oe[2:0], dbg_in8}, 5'h15);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk(q, 32'h0a);
    @(posedge clk);
    unl <= 1'b1;
    @(posedge clk);
    unl <= 1'b0;
    rseq <= 1'b0;
    settle();
    chk({dbg_u8, rhold8, pa_drv8.oe[2], pa_drv8.oe[0]}, 4'hb);
    chk({pa_drv8.out[0], dbg_u, rhold, dbg_in}, 4'h8);
    // A new reset sequence takes the pin back from debug
    @(posedge clk);
    rseq <= 1'b1;
    settle();
    chk({dbg_u8, rhold8, pa_drv8.oe[0]}, 3'h2);
    // Second reset in mid-run clears every register
    @(posedge clk);
    resetn <= 1'b0;
    rseq <= 1'b0;
    settle();
    chk({led_lvl, led_en, adc}, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, OFF_LED_EN, 32'h0, q);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule
